// File: design/acg_pkg.sv
/*
 * constants, field layout and carrier types for the adc configuration
 * register group. assumes nothing beyond a systemverilog compiler.
 */
package acg_pkg;
    // register offsets
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_GENERAL = 8'h01;
    localparam logic [7:0] ADDR_OUT_FMT = 8'h02;
    localparam logic [7:0] ADDR_AVG = 8'h03;
    localparam logic [7:0] ADDR_OPMODE = 8'h04;
    localparam logic [7:0] ADDR_CHAN_FUNC = 8'h05;
    localparam logic [7:0] ADDR_PIN_DIR = 8'h07;
    // writable bits per register, reserved bits masked off
    localparam logic [7:0] OUT_FMT_MASK = 8'hb3;
    localparam logic [7:0] AVG_MASK = 8'h07;
    // reset values
    localparam logic [7:0] OUT_FMT_RESET = 8'h00;
    localparam logic [7:0] AVG_RESET = 8'h00;
    localparam logic [7:0] OPMODE_RESET = 8'h00;
    localparam logic [7:0] CHAN_FUNC_RESET = 8'h00;
    localparam logic [7:0] PIN_DIR_RESET = 8'h00;
    // field positions
    localparam int FP_BIT = 7;
    localparam int APP_LSB = 4;
    localparam int SCM_LSB = 0;
    localparam int RATIO_LSB = 0;
    localparam int STOP_BIT = 7;
    localparam int MODE_LSB = 5;
    localparam int OSC_BIT = 4;
    localparam int DIV_LSB = 0;
    localparam int CRCERR_BIT = 1;
    localparam int CRCEN_BIT = 6;
    // data formatting
    localparam logic [11:0] FIXED_CODE = 12'ha5a;
    localparam logic [1:0] APP_NONE = 2'h0;
    localparam logic [1:0] APP_CHAN = 2'h1;
    localparam logic [1:0] APP_STAT = 2'h2;
    // conversion trigger modes
    localparam logic [1:0] MODE_MANUAL = 2'h0;
    localparam logic [1:0] MODE_AUTO = 2'h1;
    // sample time base per oscillator, in clk cycles per divider step
    localparam logic [8:0] HS_PRESCALE = 9'h001;
    localparam logic [8:0] LP_PRESCALE = 9'h010;

    typedef struct packed {
        logic fixed_pattern_enable;
        logic [1:0] append_sel;
        logic [1:0] serial_clock_mode;
        logic [2:0] oversampling_ratio;
        logic stop_on_crc_error;
        logic [1:0] conversion_mode;
        logic oscillator_select;
        logic [3:0] clk_div;
        logic [7:0] chan_func;
        logic [7:0] pin_dir;
    } acg_cfg_t;

    typedef struct packed {
        logic [11:0] data;
        logic [3:0] chan;
        logic [3:0] status;
    } acg_conv_t;

    // number of samples averaged for an oversampling code
    function automatic logic [7:0] acg_avg_count(input logic [2:0] ratio);
        acg_avg_count = 8'h01 << ratio;
    endfunction : acg_avg_count
endpackage : acg_pkg

// File: design/acg_result_fmt.sv
/*
 * output word formatter: fixed pattern substitution and tail nibble.
 * assumes conversion results arrive on clk as single-cycle strobes.
 */
`timescale 1ns/1ps
`default_nettype none
module acg_result_fmt (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // configuration and result in
    input wire acg_pkg::acg_cfg_t cfg,
    input wire logic conv_valid,
    input wire acg_pkg::acg_conv_t conv,
    // formatted word out
    output logic [15:0] out_word,
    output logic out_tail_valid,
    output logic out_valid
);
    wire logic [11:0] body;
    wire logic [3:0] tail;
    wire logic has_tail;

    // reserved append code falls back to no tail
    assign body = cfg.fixed_pattern_enable ? acg_pkg::FIXED_CODE : conv.data;
    assign has_tail = (cfg.append_sel == acg_pkg::APP_CHAN) ||
                      (cfg.append_sel == acg_pkg::APP_STAT);
    assign tail = (cfg.append_sel == acg_pkg::APP_CHAN) ? conv.chan :
                  (cfg.append_sel == acg_pkg::APP_STAT) ? conv.status : 4'h0;

    always_ff @(posedge clk) begin
        if (srst) begin
            out_word <= 16'h0000;
            out_tail_valid <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            out_valid <= conv_valid;
            if (conv_valid) begin
                out_word <= {body, tail};
                out_tail_valid <= has_tail;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    AST_FIXED_PAT: assert property (conv_valid && cfg.fixed_pattern_enable
        |=> out_valid && out_word[15:4] == acg_pkg::FIXED_CODE)
        else $error("fixed pattern not returned");
    AST_APPEND: assert property (conv_valid && cfg.append_sel == acg_pkg::APP_CHAN
        |=> out_tail_valid && out_word[3:0] == $past(conv.chan))
        else $error("channel id not appended");
    AST_NO_TAIL: assert property (conv_valid && !cfg.append_sel[0]
        && cfg.append_sel != acg_pkg::APP_STAT |=> !out_tail_valid && out_word[3:0] == 4'h0)
        else $error("tail present without append");
endmodule : acg_result_fmt
`default_nettype wire

// File: design/acg_mode_ctrl.sv
/*
 * conversion trigger, autonomous sample timer and pin override.
 * assumes the crc error flag and host trigger are on clk already.
 */
`timescale 1ns/1ps
`default_nettype none
module acg_mode_ctrl (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // configuration and status
    input wire acg_pkg::acg_cfg_t cfg,
    input wire logic crc_flag,
    input wire logic host_conv_req,
    // control out
    output logic conv_start,
    output logic seq_active,
    output logic [7:0] gpio_sel,
    output logic [7:0] gpio_dir_out
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RUN = 3'b010,
        ST_PAUSE = 3'b100
    } acg_seq_t;

    acg_seq_t st;
    acg_seq_t next_st;
    logic [8:0] cnt;
    wire logic halt;
    wire logic auto_mode;
    wire logic [8:0] prescale;
    wire logic [8:0] period;
    wire logic tick;

    // halt only when stop-on-error is armed; otherwise the flag is ignored
    assign halt = cfg.stop_on_crc_error & crc_flag;
    assign auto_mode = cfg.conversion_mode == acg_pkg::MODE_AUTO;
    assign prescale = cfg.oscillator_select ? acg_pkg::LP_PRESCALE
                                            : acg_pkg::HS_PRESCALE;
    assign period = 9'(prescale * (9'(cfg.clk_div) + 9'h001));
    assign tick = (st == ST_RUN) && (cnt >= period - 9'h001);

    // sequencer state; reserved mode codes park it in idle
    always_comb begin
        case (st)
            ST_IDLE: next_st = !auto_mode ? ST_IDLE : (halt ? ST_PAUSE : ST_RUN);
            ST_RUN: next_st = !auto_mode ? ST_IDLE : (halt ? ST_PAUSE : ST_RUN);
            ST_PAUSE: next_st = !auto_mode ? ST_IDLE : (halt ? ST_PAUSE : ST_RUN);
            default: next_st = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st <= ST_IDLE;
            cnt <= 9'h000;
            conv_start <= 1'b0;
            seq_active <= 1'b0;
            gpio_sel <= 8'h00;
            gpio_dir_out <= 8'h00;
        end else begin
            st <= next_st;
            cnt <= (st != ST_RUN || tick) ? 9'h000 : cnt + 9'h001;
            conv_start <= auto_mode ? tick : (cfg.conversion_mode == acg_pkg::MODE_MANUAL
                                              && host_conv_req);
            seq_active <= next_st == ST_RUN;
            // stored config is untouched, so clearing the flag restores it
            gpio_sel <= halt ? 8'h00 : cfg.chan_func;
            gpio_dir_out <= halt ? 8'h00 : cfg.chan_func & cfg.pin_dir;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    sequence s_halted;
        auto_mode && halt;
    endsequence
    sequence s_released;
        auto_mode && !halt;
    endsequence
    AST_HALT_ANALOG: assert property (s_halted |=> gpio_sel == 8'h00 && !seq_active)
        else $error("pins not forced analog on crc error");
    AST_RESUME: assert property (s_halted ##1 s_released |=> seq_active
        && gpio_sel == $past(cfg.chan_func))
        else $error("sequencing not resumed after clear");
    AST_KEEP_PINS: assert property (!cfg.stop_on_crc_error && crc_flag
        |=> gpio_sel == $past(cfg.chan_func))
        else $error("pins changed without stop-on-error");
    AST_MANUAL: assert property (cfg.conversion_mode == acg_pkg::MODE_MANUAL
        && host_conv_req |=> conv_start)
        else $error("manual trigger lost");
    AST_DIV_PERIOD: assert property (auto_mode && st == ST_RUN && !tick
        |=> !conv_start)
        else $error("sample before divider period");
    AST_RSVD_MODE: assert property (cfg.conversion_mode[1]
        |=> !conv_start && !seq_active)
        else $error("reserved conversion mode started conversions");
endmodule : acg_mode_ctrl
`default_nettype wire

// File: design/acg_config_regs.sv
/*
 * adc configuration register group: register port, crc error flag,
 * output format, averaging, operating mode and pin function registers.
 * assumes the spi frame decoder and crc checker run on clk and present
 * single-cycle register strobes and error pulses.
 */
`timescale 1ns/1ps
`default_nettype none
// Function
// - fixed pattern replaces every conversion result
// - append selector picks none, channel, status
// - reserved bits always read back zero
// - two-bit serial clock polarity/phase mode
// - oversampling code sets averaged sample count
// - stop bit clear: crc error ignored
// - stop bit set: force analog, pause
// - conversion mode selects manual or autonomous
// - oscillator bit picks fast or low-power
// - divider sets autonomous sampling rate
// - channel function bit: analog or gpio
// - direction bit: digital input or output
// - config registers reset to zero
// - crc flag blocks writes except 0x00/0x01
// - crc enable gates the crc error flag
module acg_config_regs (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // register port from the serial frame decoder
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rd_valid,
    output logic reg_wr_blocked,
    // crc checker
    input wire logic crc_err_det,
    output logic crc_enable,
    output logic input_crc_error_flag,
    // conversion results and host trigger
    input wire logic host_conv_req,
    input wire logic conv_valid,
    input wire acg_pkg::acg_conv_t conv,
    output logic [15:0] out_word,
    output logic out_tail_valid,
    output logic out_valid,
    // configuration towards the converter and interface
    output logic [1:0] serial_clock_mode,
    output logic [2:0] oversampling_ratio,
    output logic [7:0] avg_samples,
    output logic oscillator_select,
    output logic conv_start,
    output logic seq_active,
    output logic [7:0] gpio_sel,
    output logic [7:0] gpio_dir_out
);
    logic [7:0] output_format_config;
    logic [7:0] averaging_config;
    logic [7:0] operating_mode_config;
    logic [7:0] channel_function_select;
    logic [7:0] digital_pin_direction;
    acg_pkg::acg_cfg_t cfg;
    wire logic hit_status;
    wire logic hit_general;
    wire logic wr_ok;
    wire logic flag_clr;
    wire logic flag_set;
    wire logic [7:0] rd_mux;
    wire logic [7:0] status_rd;
    wire logic [7:0] general_rd;

    // address decode
    assign hit_status = reg_addr == acg_pkg::ADDR_STATUS;
    assign hit_general = reg_addr == acg_pkg::ADDR_GENERAL;
    // while the flag stands only status and general may be written
    assign wr_ok = reg_wr_en && (!input_crc_error_flag || hit_status
                                 || hit_general);
    assign flag_clr = wr_ok && hit_status && reg_wdata[acg_pkg::CRCERR_BIT];
    // a new error while crc is off is not a fault of this interface
    assign flag_set = crc_err_det && crc_enable;

    // status and general views hold only the bits this block owns
    assign status_rd = 8'(input_crc_error_flag) << acg_pkg::CRCERR_BIT;
    assign general_rd = 8'(crc_enable) << acg_pkg::CRCEN_BIT;

    // read selection; unmapped offsets read zero
    assign rd_mux = hit_status ? status_rd :
                    hit_general ? general_rd :
                    reg_addr == acg_pkg::ADDR_OUT_FMT ? output_format_config :
                    reg_addr == acg_pkg::ADDR_AVG ? averaging_config :
                    reg_addr == acg_pkg::ADDR_OPMODE ? operating_mode_config :
                    reg_addr == acg_pkg::ADDR_CHAN_FUNC ? channel_function_select :
                    reg_addr == acg_pkg::ADDR_PIN_DIR ? digital_pin_direction :
                    8'h00;

    // field view of the stored registers
    assign cfg.fixed_pattern_enable = output_format_config[acg_pkg::FP_BIT];
    assign cfg.append_sel = output_format_config[acg_pkg::APP_LSB +: 2];
    assign cfg.serial_clock_mode = output_format_config[acg_pkg::SCM_LSB +: 2];
    assign cfg.oversampling_ratio = averaging_config[acg_pkg::RATIO_LSB +: 3];
    assign cfg.stop_on_crc_error = operating_mode_config[acg_pkg::STOP_BIT];
    assign cfg.conversion_mode = operating_mode_config[acg_pkg::MODE_LSB +: 2];
    assign cfg.oscillator_select = operating_mode_config[acg_pkg::OSC_BIT];
    assign cfg.clk_div = operating_mode_config[acg_pkg::DIV_LSB +: 4];
    assign cfg.chan_func = channel_function_select;
    assign cfg.pin_dir = digital_pin_direction;

    // writable registers; reserved bits are masked so they never store
    always_ff @(posedge clk) begin
        if (srst) begin
            output_format_config <= acg_pkg::OUT_FMT_RESET;
            averaging_config <= acg_pkg::AVG_RESET;
            operating_mode_config <= acg_pkg::OPMODE_RESET;
            channel_function_select <= acg_pkg::CHAN_FUNC_RESET;
            digital_pin_direction <= acg_pkg::PIN_DIR_RESET;
        end else if (wr_ok) begin
            case (reg_addr)
                acg_pkg::ADDR_OUT_FMT:
                    output_format_config <= reg_wdata & acg_pkg::OUT_FMT_MASK;
                acg_pkg::ADDR_AVG: averaging_config <= reg_wdata & acg_pkg::AVG_MASK;
                acg_pkg::ADDR_OPMODE: operating_mode_config <= reg_wdata;
                acg_pkg::ADDR_CHAN_FUNC: channel_function_select <= reg_wdata;
                acg_pkg::ADDR_PIN_DIR: digital_pin_direction <= reg_wdata;
                default: ;
            endcase
        end
    end

    // crc enable and error flag; a set in the clearing cycle wins
    always_ff @(posedge clk) begin
        if (srst) begin
            crc_enable <= 1'b0;
            input_crc_error_flag <= 1'b0;
        end else begin
            if (wr_ok && hit_general) begin
                crc_enable <= reg_wdata[acg_pkg::CRCEN_BIT];
            end
            input_crc_error_flag <= flag_set || (input_crc_error_flag && !flag_clr);
        end
    end

    // read answer and blocked-write pulse, one cycle after the strobe
    always_ff @(posedge clk) begin
        if (srst) begin
            reg_rdata <= 8'h00;
            reg_rd_valid <= 1'b0;
            reg_wr_blocked <= 1'b0;
        end else begin
            reg_rd_valid <= reg_rd_en;
            reg_rdata <= reg_rd_en ? rd_mux : reg_rdata;
            reg_wr_blocked <= reg_wr_en && !wr_ok;
        end
    end

    // registered copies for the converter; averaging count is decoded once
    always_ff @(posedge clk) begin
        if (srst) begin
            serial_clock_mode <= 2'h0;
            oversampling_ratio <= 3'h0;
            avg_samples <= 8'h01;
            oscillator_select <= 1'b0;
        end else begin
            serial_clock_mode <= cfg.serial_clock_mode;
            oversampling_ratio <= cfg.oversampling_ratio;
            avg_samples <= acg_pkg::acg_avg_count(cfg.oversampling_ratio);
            oscillator_select <= cfg.oscillator_select;
        end
    end

    // output word formatting
    acg_result_fmt u_fmt (
        .clk(clk),
        .srst(srst),
        .cfg(cfg),
        .conv_valid(conv_valid),
        .conv(conv),
        .out_word(out_word),
        .out_tail_valid(out_tail_valid),
        .out_valid(out_valid)
    );

    // trigger, sampling timer and pin override
    acg_mode_ctrl u_mode (
        .clk(clk),
        .srst(srst),
        .cfg(cfg),
        .crc_flag(input_crc_error_flag),
        .host_conv_req(host_conv_req),
        .conv_start(conv_start),
        .seq_active(seq_active),
        .gpio_sel(gpio_sel),
        .gpio_dir_out(gpio_dir_out)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    sequence s_rd(logic [7:0] a);
        reg_rd_en && reg_addr == a;
    endsequence
    AST_RSVD_ZERO: assert property (s_rd(acg_pkg::ADDR_OUT_FMT)
        |=> reg_rd_valid && (reg_rdata & ~acg_pkg::OUT_FMT_MASK) == 8'h00)
        else $error("reserved bits read nonzero");
    AST_RESET_ZERO: assert property ($past(srst) |-> averaging_config == 8'h00
        && operating_mode_config == 8'h00 && channel_function_select == 8'h00
        && digital_pin_direction == 8'h00 && gpio_sel == 8'h00)
        else $error("config not zero after reset");
    AST_BLOCK: assert property (reg_wr_en && input_crc_error_flag && !hit_status
        && !hit_general |=> reg_wr_blocked && $stable(operating_mode_config)
        && $stable(output_format_config) && $stable(channel_function_select))
        else $error("write not blocked under crc error");
    AST_SET_WINS: assert property (crc_err_det && crc_enable
        |=> input_crc_error_flag)
        else $error("crc error flag lost");
    AST_CRC_OFF: assert property (crc_err_det && !crc_enable && !input_crc_error_flag
        && !(reg_wr_en && hit_general) |=> !input_crc_error_flag)
        else $error("flag set with crc disabled");
    AST_READBACK: assert property (wr_ok && reg_addr == acg_pkg::ADDR_OPMODE
        ##1 s_rd(acg_pkg::ADDR_OPMODE) |=> reg_rdata == $past(reg_wdata, 2))
        else $error("readback differs from write");
    AST_AVG_COUNT: assert property (wr_ok && reg_addr == acg_pkg::ADDR_AVG
        |=> ##1 avg_samples == 8'(8'h01 << $past(reg_wdata[2:0], 2)))
        else $error("averaging count wrong");
    AST_SCM: assert property (wr_ok && reg_addr == acg_pkg::ADDR_OUT_FMT
        |=> ##1 serial_clock_mode == $past(reg_wdata[1:0], 2))
        else $error("serial clock mode not applied");
endmodule : acg_config_regs
`default_nettype wire

// File: testbench/acg_host_model.sv
/*
 * host model for the register port of the adc configuration group.
 * assumes the device samples strobes on the rising edge of clk.
 */
`timescale 1ns/1ps
`default_nettype none
module acg_host_model (
    // clock
    input wire logic clk,
    // register port towards the device
    output logic reg_wr_en,
    output logic reg_rd_en,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    // serial mode chosen by the device
    input wire logic [1:0] serial_clock_mode
);
    logic [1:0] bus_mode;

    // idle port at time zero
    initial begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end

    // host follows the selected clock mode for later frames
    always @(posedge clk) begin
        bus_mode <= serial_clock_mode;
    end

    // released lines show the inverse so stale values never match
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_wr_en = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr_en = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : wr

    // write, then read the same address on the very next edge
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_wr_en = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b1;
        @(negedge clk);
        reg_rd_en = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : wr_rd

    task automatic rd(input logic [7:0] a);
        @(negedge clk);
        reg_rd_en = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_rd_en = 1'b0;
        reg_addr = ~a;
    endtask : rd
endmodule : acg_host_model
`default_nettype wire

// File: testbench/acg_config_regs_tb.sv
/*
 * self-checking bench for the adc configuration register group.
 * assumes acg_pkg and the design files are compiled before this one.
 */
`timescale 1ns/1ps
`default_nettype none
module acg_config_regs_tb;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic crc_err_det = 1'b0;
    logic host_conv_req = 1'b0;
    logic conv_valid = 1'b0;
    acg_pkg::acg_conv_t conv = '0;
    wire logic reg_wr_en, reg_rd_en;
    wire logic [7:0] reg_addr, reg_wdata;
    logic [7:0] reg_rdata, avg_samples, gpio_sel, gpio_dir_out;
    logic reg_rd_valid, reg_wr_blocked, crc_enable, input_crc_error_flag;
    logic [15:0] out_word;
    logic out_tail_valid, out_valid, oscillator_select, conv_start, seq_active;
    logic [1:0] serial_clock_mode;
    logic [2:0] oversampling_ratio;
    int fail_count = 0;
    int compares = 0;
    int seed = 32'h6235;
    logic [7:0] rd_q[$];
    logic [15:0] fmt_q[$];
    logic [31:0] r;
    logic [7:0] pa, pb;

    always #2 clk = ~clk;

    acg_host_model i_host (.clk(clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .serial_clock_mode(serial_clock_mode));

    acg_config_regs i_dut (.clk(clk), .srst(srst), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .reg_wr_blocked(reg_wr_blocked),
        .crc_err_det(crc_err_det), .crc_enable(crc_enable),
        .input_crc_error_flag(input_crc_error_flag), .host_conv_req(host_conv_req),
        .conv_valid(conv_valid), .conv(conv), .out_word(out_word),
        .out_tail_valid(out_tail_valid), .out_valid(out_valid),
        .serial_clock_mode(serial_clock_mode), .oversampling_ratio(oversampling_ratio),
        .avg_samples(avg_samples), .oscillator_select(oscillator_select),
        .conv_start(conv_start), .seq_active(seq_active), .gpio_sel(gpio_sel),
        .gpio_dir_out(gpio_dir_out));

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask : idle

    // read with the expected value noted for the monitor
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        rd_q.push_back(exp);
        i_host.rd(a);
    endtask : rd_chk

    task automatic pulse_err();
        @(negedge clk);
        crc_err_det = 1'b1;
        @(negedge clk);
        crc_err_det = 1'b0;
    endtask : pulse_err

    // cycles between two starts, bounded so a dead timer cannot hang
    task automatic period_chk(input int exp);
        int n;
        n = 0;
        while (conv_start !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (conv_start !== 1'b1 && n < 100);
        check("start_period", 16'(n), 16'(exp));
    endtask : period_chk

    task automatic wrap_up();
        if (rd_q.size() != 0 || fmt_q.size() != 0) fail_count++;
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrap_up

    // monitor: every answer takes the oldest note
    always @(negedge clk) begin
        if (reg_rd_valid === 1'b1) begin
            if (rd_q.size() == 0) check("rd_unexpected", 16'h0, 16'h1);
            else check("reg_rdata", 16'(reg_rdata), 16'(rd_q.pop_front()));
        end
        if (out_valid === 1'b1) begin
            if (fmt_q.size() == 0) check("fmt_unexpected", 16'h0, 16'h1);
            else check("out_word", out_word, fmt_q.pop_front());
        end
    end

    initial begin
        #200000;
        fail_count++;
        wrap_up();
    end

    initial begin
        idle(2);
        srst = 1'b0;
        foreach (pa[i]) rd_chk(8'(i < 5 ? i + 2 : 7), 8'h00);
        check("avg_reset", 16'(avg_samples), 16'h1);
        rd_chk(8'h06, 8'h00);
        i_host.wr(8'h02, 8'hff);
        i_host.wr(8'h03, 8'hff);
        rd_chk(8'h02, 8'hb3);
        rd_chk(8'h03, 8'h07);
        for (int k = 0; k < 8; k++) begin
            i_host.wr(8'h02, 8'(k % 4));
            i_host.wr(8'h03, 8'(k));
            idle(2);
            check("serial_clock_mode", 16'(serial_clock_mode), 16'(k % 4));
            check("avg_samples", 16'(avg_samples), 16'(1 << k));
            check("ratio_out", 16'(oversampling_ratio), 16'(k));
            check("host_mode", 16'(i_host.bus_mode), 16'(k % 4));
        end
        // fixed pattern and tail selector, all combinations
        for (int k = 0; k < 8; k++) begin
            i_host.wr(8'h02, {k[2], 1'b0, k[1:0], 4'h0});
            idle(2);
            r = $random(seed);
            @(negedge clk);
            conv = r[19:0];
            conv_valid = 1'b1;
            fmt_q.push_back({k[2] ? 12'ha5a : r[19:8],
                k[1:0] == 2'h1 ? r[7:4] : (k[1:0] == 2'h2 ? r[3:0] : 4'h0)});
            @(negedge clk);
            conv_valid = 1'b0;
            check("tail_valid", 16'(out_tail_valid), 16'(k[1:0] == 2'h1 || k[1:0] == 2'h2));
        end
        // manual trigger
        check("no_start", 16'(conv_start), 16'h0);
        host_conv_req = 1'b1;
        @(negedge clk);
        host_conv_req = 1'b0;
        check("manual_start", 16'(conv_start), 16'h1);
        i_host.wr(8'h04, 8'h23);
        period_chk(4);
        i_host.wr(8'h04, 8'h30);
        idle(2);
        check("oscillator_select", 16'(oscillator_select), 16'h1);
        period_chk(16);
        rd_q.push_back(8'h20);
        i_host.wr_rd(8'h04, 8'h20);
        r = $random(seed);
        pa = r[7:0];
        pb = r[15:8];
        i_host.wr(8'h05, pa);
        i_host.wr(8'h07, pb);
        rd_chk(8'h04, 8'h20);
        rd_chk(8'h07, pb);
        idle(2);
        check("gpio_sel", 16'(gpio_sel), 16'(pa));
        check("gpio_dir", 16'(gpio_dir_out), 16'(pa & pb));
        i_host.wr(8'h01, 8'h40);
        check("crc_enable", 16'(crc_enable), 16'h1);
        rd_chk(8'h01, 8'h40);
        pulse_err();
        idle(2);
        check("crc_flag", 16'(input_crc_error_flag), 16'h1);
        check("keep_pins", 16'(gpio_sel), 16'(pa));
        check("keep_seq", 16'(seq_active), 16'h1);
        rd_chk(8'h00, 8'h02);
        i_host.wr(8'h05, ~pa);
        check("blocked", 16'(reg_wr_blocked), 16'h1);
        rd_chk(8'h05, pa);
        i_host.wr(8'h00, 8'h02);
        idle(2);
        check("flag_clear", 16'(input_crc_error_flag), 16'h0);
        i_host.wr(8'h04, 8'ha0);
        idle(2);
        pulse_err();
        idle(2);
        check("halt_pins", 16'(gpio_sel), 16'h0);
        check("halt_dir", 16'(gpio_dir_out), 16'h0);
        check("halt_seq", 16'(seq_active), 16'h0);
        i_host.wr(8'h00, 8'h02);
        idle(3);
        check("restore_pins", 16'(gpio_sel), 16'(pa));
        check("resume_seq", 16'(seq_active), 16'h1);
        i_host.wr(8'h01, 8'h00);
        pulse_err();
        idle(2);
        check("crc_off", 16'(input_crc_error_flag), 16'h0);
        // reserved conversion mode: no starts, even on a host request
        i_host.wr(8'h04, 8'h60);
        idle(2);
        host_conv_req = 1'b1;
        @(negedge clk);
        host_conv_req = 1'b0;
        check("rsvd_mode_start", 16'(conv_start), 16'h0);
        check("rsvd_mode_seq", 16'(seq_active), 16'h0);
        idle(4);
        wrap_up();
    end
endmodule : acg_config_regs_tb
`default_nettype wire
